/* File: design/padc_ctrl.v */
// Control logic of an 8-bit SAR converter with a parallel host port.
`timescale 1ns/10ps
`default_nettype none
`include "padc_defs.vh"

module padc_ctrl #(
  parameter DATA_W = 8
) (
  input  wire              ref_clk_in,
  input  wire              rst_n_in,
  input  wire              cs_n_in,
  input  wire              rd_n_in,
  input  wire              wr_n_in,
  input  wire              conv_trigger_n_in,
  input  wire [DATA_W-1:0] data_in,
  input  wire              cmp_in,
  output reg  [DATA_W-1:0] data_out,
  output reg  [DATA_W-1:0] data_oe_out,
  output reg  [DATA_W-1:0] dac_code_out,
  output reg               sample_out,
  output reg               status_out,
  output reg               auto_pd_out,
  output reg               soft_pd_out,
  output reg               ext_clk_sel_out,
  output reg               osc_fast_out,
  output reg  [5:0]        ctrl_word_zero_out,
  output reg  [5:0]        ctrl_word_one_out
);

  // ------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_SAMPLE = 4'h2;
  localparam [3:0] ST_CONV   = 4'h4;
  localparam [3:0] ST_DONE   = 4'h8;
  localparam integer PD_CYC_I   = `PADC_AUTO_PD_CYC;
  localparam integer CONV_CYC_I = `PADC_CONV_CLKS;
  localparam integer SW_SMP_I   = `PADC_SW_SAMPLE_CLKS;
  // Counts are cut to their counter widths on purpose.
  localparam [3:0] PD_CYC    = PD_CYC_I[3:0];
  localparam [4:0] CONV_CYC  = CONV_CYC_I[4:0];
  localparam [2:0] SW_SMP    = SW_SMP_I[2:0];

  reg [1:0] rst_sync_r;
  wire      rst_n = rst_sync_r[1];

  // Reset is asserted at once and released only after two clean edges.
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  reg [3:0] meta_r;
  reg [3:0] sync_r;
  reg [3:0] prev_r;
  reg [DATA_W-1:0] dmeta_r;
  reg [DATA_W-1:0] dsync_r;

  // Pins are asynchronous; the first stage is read by the second only.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      meta_r  <= 4'hF;
      sync_r  <= 4'hF;
      prev_r  <= 4'hF;
      dmeta_r <= {DATA_W{1'b0}};
      dsync_r <= {DATA_W{1'b0}};
    end else begin
      meta_r  <= {cs_n_in, rd_n_in, wr_n_in, conv_trigger_n_in};
      sync_r  <= meta_r;
      prev_r  <= sync_r;
      dmeta_r <= data_in;
      dsync_r <= dmeta_r;
    end
  end

  wire cs_n   = sync_r[3];
  wire rd_n   = sync_r[2];
  wire wr_n   = sync_r[1];
  wire trg_n  = sync_r[0];
  wire rd_fall = prev_r[2] & ~rd_n & ~cs_n;
  wire rd_rise = ~prev_r[2] & rd_n & ~cs_n;
  wire wr_rise = ~prev_r[1] & wr_n & ~cs_n;
  wire trg_fall = prev_r[0] & ~trg_n;
  wire trg_rise = ~prev_r[0] & trg_n;

  // ------------------------------------------------------------
  // Control words
  // ------------------------------------------------------------
  reg [5:0] c0_r;
  reg [5:0] c1_r;
  reg       wr_seen_r;

  // Host writes land by index; a read seen with the write strobe never
  // having risen loads defaults, so a grounded strobe stays unprogrammable.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      c0_r      <= `PADC_CTRL_RESET;
      c1_r      <= `PADC_CTRL_RESET;
      wr_seen_r <= 1'b0;
    end else if (wr_rise) begin
      wr_seen_r <= 1'b1;
      if (dsync_r[7:6] == `PADC_IDX_CTRL0) begin
        c0_r <= dsync_r[5:0];
      end else if (dsync_r[7:6] == `PADC_IDX_CTRL1) begin
        c1_r <= dsync_r[5:0];
      end
    end else if (rd_fall && !wr_n && !wr_seen_r) begin
      c0_r <= `PADC_CTRL_RESET;
      c1_r <= `PADC_CTRL_RESET;
    end
  end

  wire sw_start = c0_r[`PADC_C0_STARTSEL];
  wire eoc_mode = c0_r[`PADC_C0_EOCMODE];

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  reg [3:0]        state_r;
  reg [3:0]        state_nxt;
  reg [4:0]        cnt_r;
  reg [2:0]        bit_r;
  reg [DATA_W-1:0] sar_r;
  reg [DATA_W-1:0] result_r;

  // Software start samples on write (first) or read rise; the converter
  // then samples for a fixed number of clocks before converting.
  wire sw_go = sw_start & (wr_rise | rd_rise);
  wire hw_go = ~sw_start & trg_fall;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   if (hw_go || sw_go) state_nxt = ST_SAMPLE;
      ST_SAMPLE: if ((!sw_start && trg_rise) || (sw_start && cnt_r[2:0] == SW_SMP - 3'h1)) state_nxt = ST_CONV;
      ST_CONV:   if (cnt_r == CONV_CYC - 5'h1) state_nxt = ST_DONE;
      ST_DONE:   state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  // The SAR takes two clocks per bit over the sixteen conversion clocks:
  // the trial code leaves through a register, so the comparator answer
  // is only valid one clock after the trial bit is set.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 5'h00;
      bit_r    <= 3'h7;
      sar_r    <= {DATA_W{1'b0}};
      result_r <= {DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= 5'h00;
      end else begin
        cnt_r <= cnt_r + 5'h01;
      end
      if (state_r == ST_SAMPLE && state_nxt == ST_CONV) begin
        bit_r <= 3'h7;
        sar_r <= {1'b1, {(DATA_W-1){1'b0}}};
      end else if (state_r == ST_CONV && cnt_r[0]) begin
        sar_r[bit_r] <= cmp_in;
        if (bit_r != 3'h0) begin
          sar_r[bit_r - 3'h1] <= 1'b1;
          bit_r <= bit_r - 3'h1;
        end
      end
      if (state_r == ST_DONE) begin
        result_r <= sar_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs, power states and bus drive
  // ------------------------------------------------------------
  reg [3:0] pd_cnt_r;
  reg       rd_act_r;
  wire [DATA_W-1:0] code = c1_r[`PADC_C1_TWOS] ? {~result_r[DATA_W-1], result_r[DATA_W-2:0]} : result_r;

  // Auto power-down follows each conversion after the settle delay;
  // software power-down is a separate output, registered from control word zero and not gating it.
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt_r           <= 4'h0;
      rd_act_r           <= 1'b0;
      data_out           <= {DATA_W{1'b0}};
      data_oe_out        <= {DATA_W{1'b0}};
      dac_code_out       <= {DATA_W{1'b0}};
      sample_out         <= 1'b0;
      status_out         <= 1'b1;
      auto_pd_out        <= 1'b0;
      soft_pd_out        <= 1'b0;
      ext_clk_sel_out    <= 1'b0;
      osc_fast_out       <= 1'b0;
      ctrl_word_zero_out <= `PADC_CTRL_RESET;
      ctrl_word_one_out  <= `PADC_CTRL_RESET;
    end else begin
      if (state_r == ST_DONE) begin
        pd_cnt_r <= PD_CYC;
      end else if (pd_cnt_r != 4'h0) begin
        pd_cnt_r <= pd_cnt_r - 4'h1;
      end
      if (state_r != ST_IDLE) begin
        auto_pd_out <= 1'b0;
      end else if (pd_cnt_r == 4'h1) begin
        auto_pd_out <= 1'b1;
      end
      soft_pd_out <= c0_r[`PADC_C0_SWPDN];
      if (rd_fall) begin
        rd_act_r <= 1'b1;
      end else if (rd_n || cs_n) begin
        rd_act_r <= 1'b0;
      end
      data_out    <= code;
      data_oe_out <= {DATA_W{rd_act_r | rd_fall}};
      dac_code_out <= sar_r;
      sample_out  <= (state_r == ST_SAMPLE);
      // Level mode is low across conversion; pulse mode gives one low
      // cycle per finished conversion.
      if (eoc_mode) begin
        status_out <= ~(state_r == ST_CONV);
      end else begin
        status_out <= ~(state_r == ST_DONE);
      end
      ext_clk_sel_out    <= c0_r[`PADC_C0_CLKSEL];
      osc_fast_out       <= c1_r[`PADC_C1_OSCFAST];
      ctrl_word_zero_out <= c0_r;
      ctrl_word_one_out  <= c1_r;
    end
  end

endmodule // padc_ctrl
`default_nettype wire

/* File: design/padc_defs.vh */
// Constants for the parallel converter host-side control block.
`ifndef PADC_DEFS_VH
`define PADC_DEFS_VH
// ------------------------------------------------------------
// Control word addressing and fields
// ------------------------------------------------------------
`define PADC_IDX_CTRL0      2'h0
`define PADC_IDX_CTRL1      2'h1
`define PADC_C0_STARTSEL    5
`define PADC_C0_EOCMODE     4
`define PADC_C0_CLKSEL      3
`define PADC_C0_SWPDN       2
`define PADC_C1_OSCFAST     4
`define PADC_C1_TWOS        1
`define PADC_CTRL_RESET     6'h00
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PADC_CLK_PERIOD_PS  5000
`define PADC_AUTO_PD_NS     50
`define PADC_AUTO_PD_CYC    ((`PADC_AUTO_PD_NS * 1000 + `PADC_CLK_PERIOD_PS - 1) / `PADC_CLK_PERIOD_PS)
`define PADC_CONV_CLKS      16
`define PADC_SW_SAMPLE_CLKS 6
`define PADC_INT_PULSE_CYC  1
`endif

/* File: testbench/padc_ctrl_properties.sv */
// Port timing checker for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module padc_props (
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       cs_n_in,
  input wire logic       rd_n_in,
  input wire logic [7:0] data_oe_out,
  input wire logic       status_out,
  input wire logic       auto_pd_out,
  input wire logic       soft_pd_out,
  input wire logic [5:0] ctrl_word_zero_out
);
  // Pin syncs add a few cycles of slack, so idle checks wait eight cycles.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_oe_all; data_oe_out == 8'h00 || data_oe_out == 8'hFF; endproperty
  a_oe_all: assert property (p_oe_all) else $error("bus enable split");
  property p_cs_idle; cs_n_in [*8] |-> data_oe_out == 8'h00; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("bus driven unselected");
  property p_oe_why; $rose(data_oe_out[0]) |-> $past(!rd_n_in, 2) && $past(!cs_n_in, 2); endproperty
  a_oe_why: assert property (p_oe_why) else $error("bus driven early");
  property p_cfg_hold; cs_n_in [*8] |=> $stable(ctrl_word_zero_out); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("control changed");
  property p_swpd; $rose(ctrl_word_zero_out[2]) |-> ##[0:3] soft_pd_out; endproperty
  a_swpd: assert property (p_swpd) else $error("no power-down");
  property p_int; !ctrl_word_zero_out[4] && $fell(status_out) |=> status_out; endproperty
  a_int: assert property (p_int) else $error("pulse too long");
  property p_eoc; ctrl_word_zero_out[4] && $fell(status_out) |-> !status_out [*8]; endproperty
  a_eoc: assert property (p_eoc) else $error("conversion short");
  property p_apd; !ctrl_word_zero_out[4] && $fell(status_out) |-> ##[8:12] auto_pd_out; endproperty
  a_apd: assert property (p_apd) else $error("no auto power-down");
endmodule // padc_props
bind padc_ctrl padc_props i_props (.ref_clk_in, .rst_n_in, .cs_n_in, .rd_n_in, .data_oe_out, .status_out,
  .auto_pd_out, .soft_pd_out, .ctrl_word_zero_out);
`default_nettype wire

/* File: testbench/padc_host_model.sv */
// Host bus model driving the converter's parallel port.
`timescale 1ns/10ps
`default_nettype none
module padc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic [7:0] dev_oe_in,
  output var  logic       cs_n_out,
  output var  logic       rd_n_out,
  output var  logic       wr_n_out,
  output wire logic [7:0] bus_out
);
  logic [7:0] val_r;
  logic       drv_r;
  // When set, the write strobe is held at ground as a non-programming host does.
  logic       wr_tie = 1'b0;
  // Released lines show the inverse byte, so a stale value never passes.
  assign bus_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & (drv_r ? val_r : ~val_r));
  initial {cs_n_out, rd_n_out, wr_n_out, drv_r, val_r} = 12'hE00;
  // One strobe cycle; each level is held hold_n clocks, so slow hosts are modelled too.
  task automatic xfer(input logic rd, input logic cs, input logic [7:0] b, input int hold_n, output logic [7:0] q);
    @(posedge clk_in);
    #1;
    cs_n_out = cs;
    val_r = b;
    drv_r = !rd;
    rd_n_out = !rd;
    wr_n_out = rd & !wr_tie;
    repeat (hold_n) @(posedge clk_in);
    q = bus_out;
    #1;
    rd_n_out = 1'b1;
    wr_n_out = !wr_tie;
    repeat (hold_n) @(posedge clk_in);
    #1;
    {cs_n_out, drv_r} = 2'h2;
  endtask
endmodule // padc_host_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        conv_trigger_n_in = 1'b1;
  logic [7:0]  ain = 8'hA5;
  logic [7:0]  q;
  int          err_total = 0;
  int          cmp_count = 0;
  int          k;
  wire         cs_n_in, rd_n_in, wr_n_in, sample_out, status_out, auto_pd_out, soft_pd_out;
  wire         ext_clk_sel_out, osc_fast_out;
  wire  [7:0]  data_in, data_out, data_oe_out, dac_code_out;
  wire  [5:0]  ctrl_word_zero_out, ctrl_word_one_out;
  wire  [2:0]  sig = {auto_pd_out, status_out, sample_out};
  // Comparator keeps a trial bit while the input is at or above it.
  wire         cmp_in = (ain >= dac_code_out);
  // Row: byte written, expected control word zero, expected control word one.
  logic [19:0] rows [0:5] = '{20'h04100, 20'h52112, 20'hBF112, 20'h08212, 20'h40200, 20'h00000};
  always #2.5 ref_clk_in = ~ref_clk_in;
  padc_host_model i_host (.clk_in(ref_clk_in), .dev_data_in(data_out), .dev_oe_in(data_oe_out),
    .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .bus_out(data_in));
  padc_ctrl i_dut (.ref_clk_in, .rst_n_in, .cs_n_in, .rd_n_in, .wr_n_in, .conv_trigger_n_in, .data_in, .cmp_in,
    .data_out, .data_oe_out, .dac_code_out, .sample_out, .status_out, .auto_pd_out, .soft_pd_out,
    .ext_clk_sel_out, .osc_fast_out, .ctrl_word_zero_out, .ctrl_word_one_out);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for bit s of the status group to reach v.
  task automatic wt(input int s, input logic v);
    int n;
    for (n = 0; n < 80 && sig[s] !== v; n++) @(posedge ref_clk_in);
    if (n == 80) begin
      err_total++;
      $display("BAD %0t wait %0d", $time, s);
      close_out();
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk({2'h0, ctrl_word_zero_out}, 8'h00);
    chk({6'h00, status_out, data_oe_out[0]}, 8'h02);
    i_host.xfer(0, 1, 8'h3C, 6, q);
    chk({2'h0, ctrl_word_zero_out}, 8'h00);
    for (k = 0; k < 6; k++) begin
      i_host.xfer(0, 0, rows[k][19:12], 3, q);
      repeat (3) @(posedge ref_clk_in);
      chk({2'h0, ctrl_word_zero_out}, {2'h0, rows[k][11:6]});
      chk({2'h0, ctrl_word_one_out}, {2'h0, rows[k][5:0]});
      chk({5'h00, soft_pd_out, ext_clk_sel_out, osc_fast_out}, {5'h00, rows[k][8], rows[k][9], rows[k][4]});
    end
    #1;
    conv_trigger_n_in = 1'b0;
    wt(0, 1'b1);
    #1;
    conv_trigger_n_in = 1'b1;
    wt(1, 1'b0);
    wt(2, 1'b1);
    i_host.xfer(1, 0, 8'h00, 6, q);
    chk(q, 8'hA5);
    ain = 8'h3C;
    i_host.xfer(1, 0, 8'h00, 6, q);
    chk(q, 8'hA5);
    i_host.xfer(0, 0, 8'h30, 3, q);
    i_host.xfer(0, 0, 8'h30, 3, q);
    wt(1, 1'b0);
    wt(1, 1'b1);
    i_host.xfer(1, 0, 8'h00, 6, q);
    chk(q, 8'h3C);
    // Mid-run reset, then a dummy read with the write strobe grounded.
    rst_n_in = 1'b0;
    i_host.wr_tie = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk({5'h00, status_out, auto_pd_out, data_oe_out[0]}, 8'h04);
    i_host.xfer(1, 0, 8'h00, 6, q);
    chk({2'h0, ctrl_word_zero_out}, 8'h00);
    chk({2'h0, ctrl_word_one_out}, 8'h00);
    close_out();
  end
endmodule // tb
`default_nettype wire
